// ==== hdl/tsr_pkg.sv ====
// package: constants, encodings and types of the temperature sensor serial block
`default_nettype none
package tsr_pkg;
	// word layout
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned CODE_W     = 8;
	localparam int unsigned TEMP_W     = 13;
	localparam int unsigned TEMP_LSB   = 3;
	localparam int unsigned FLAG_POS   = 2;
	localparam int unsigned BITS_W     = 5;
	localparam int unsigned RISE_W     = 6;
	// frame shape, in serial clocks
	localparam logic [5:0]  READ_CLKS  = 6'h10;
	localparam logic [5:0]  FRAME_CLKS = 6'h20;
	localparam logic [4:0]  WRITE_MAX  = 5'h10;
	localparam logic [4:0]  FALL_MAX   = 5'h10;
	localparam logic [4:0]  LAST_OE    = 5'h0d;
	localparam logic [4:0]  CODE_BITS  = 5'h08;
	localparam logic [3:0]  FIRST_IDX  = 4'he;
	// configuration codes
	localparam logic [7:0]  CODE_SHUTDOWN = 8'hff;
	localparam logic [7:0]  CODE_CONT     = 8'h00;
	// reset and fixed values
	localparam logic [15:0] TEMP_POR   = 16'hff00;
	localparam logic [1:0]  TRI_BITS   = 2'h0;
	// identity fields, values arbitrary
	localparam logic [4:0]  ID_MAKER   = 5'h0b;
	localparam logic [8:0]  ID_DEVICE  = 9'h05c;
	localparam logic [15:0] ID_WORD    = {ID_MAKER, ID_DEVICE, TRI_BITS};
	// pin synchroniser depth
	localparam int unsigned SYNC_N     = 3;
	// conversion sequencing
	typedef enum logic [1:0] {
		CV_IDLE  = 2'b00,
		CV_BUSY  = 2'b01,
		CV_DRAIN = 2'b10
	} tsr_conv_type;
endpackage : tsr_pkg
`default_nettype wire

// ==== hdl/tsr_link_if.sv ====
// interface: words passed between the system-clock side and the serial-clock side
`default_nettype none
interface tsr_link_if;
	logic [15:0] tx_word;
	logic [7:0]  rx_byte;
	logic [4:0]  rx_bits;
	modport sys (output tx_word, input rx_byte, input rx_bits);
	modport lnk (input tx_word, output rx_byte, output rx_bits);
endinterface : tsr_link_if
`default_nettype wire

// ==== hdl/tsr_link.sv ====
// serial-clock domain shifter: read word out, configuration byte in
`default_nettype none
module tsr_link (
	// serial pins
	input  wire logic serial_clock_in_i,
	input  wire logic cs_n_i,
	input  wire logic sio_i,
	output logic      sio_o,
	output logic      sio_oe_o,
	// words to and from the system side
	tsr_link_if.lnk   lk
);
	logic [5:0] rise_q;
	logic [4:0] fall_q;
	logic       out_q;
	logic       oe_q;
	logic [7:0] rx_q;
	logic [4:0] wbits_q;

	wire        in_write  = (rise_q >= tsr_pkg::READ_CLKS);
	wire        first_clk = (rise_q == 6'h00);
	wire [3:0]  nxt_idx   = tsr_pkg::FIRST_IDX - fall_q[3:0];
	wire        nxt_bit   = (fall_q < tsr_pkg::FALL_MAX - 5'h01) ? lk.tx_word[nxt_idx] : 1'b0;

	// chip select high clears the frame at once
	always_ff @(posedge serial_clock_in_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			rise_q <= '0;
		end else if (rise_q != tsr_pkg::FRAME_CLKS) begin
			rise_q <= rise_q + 6'h01;
		end
	end

	// not cleared by chip select: the system side reads it after the frame
	always_ff @(posedge serial_clock_in_i) begin
		if (!cs_n_i) begin
			if (first_clk) begin
				wbits_q <= '0;
			end else if (in_write) begin
				rx_q <= {rx_q[6:0], sio_i};
				if (wbits_q != tsr_pkg::WRITE_MAX) begin
					wbits_q <= wbits_q + 5'h01;
				end
			end
		end
	end

	always_ff @(negedge serial_clock_in_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			fall_q <= '0;
			out_q  <= 1'b0;
			oe_q   <= 1'b1;
		end else begin
			if (fall_q != tsr_pkg::FALL_MAX) begin
				fall_q <= fall_q + 5'h01;
			end
			out_q <= nxt_bit;
			oe_q  <= (fall_q < tsr_pkg::LAST_OE);
		end
	end

	// first bit must stand before any clock edge, hence the mux
	assign sio_o      = (fall_q == 5'h00) ? lk.tx_word[15] : out_q;
	assign sio_oe_o   = ~cs_n_i & oe_q;
	assign lk.rx_byte = rx_q;
	assign lk.rx_bits = wbits_q;
endmodule : tsr_link
`default_nettype wire

// ==== hdl/tsr_top.sv ====
// top: temperature sensor serial register block, system side and link
// Behaviour
// - Read word shifts out MSB first.
// - Low byte all ones enters shutdown.
// - Serial interface keeps working in shutdown.
// - Shutdown reads return identity word.
// - Identity leading five bits are maker field.
// - Other permitted code leaves shutdown, converts.
// - All-zero code selects continuous conversion.
// - Stale temperature kept until next conversion.
// - Temperature, identity read-only; configuration write-only.
// - Power-on temperature reads ff00, flag clear.
// - Two lowest read bits left undriven.
// - Converted word: 13-bit temperature, flag high.
// - Configuration 16 bits, low byte decides.
// - Out on falling, in on rising, 32 clocks.
// - Last eight bits before release are code.
// - Read never breaks conversion; refresh after read.
`default_nettype none
module tsr_top (
	// system clock and control
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_N_I,
	input  wire logic        CE_I,
	// serial link
	input  wire logic        SERIAL_CLOCK_IN_I,
	input  wire logic        CS_N_I,
	input  wire logic        SIO_I,
	output logic             SIO_O,
	output logic             SIO_OE_O,
	// converter
	output logic             CONV_START_O,
	input  wire logic        CONV_DONE_I,
	input  wire logic [12:0] CONV_RESULT_I,
	// status
	output logic             SHUTDOWN_O,
	output logic             CONV_VALID_O,
	output logic             TEST_CODE_O
);
	// permitted codes: zero or a run of ones from bit 0
	function automatic logic code_permitted(input logic [7:0] c);
		code_permitted = ((c & (c + 8'h01)) == 8'h00);
	endfunction : code_permitted

	function automatic logic code_shutdown(input logic [7:0] c);
		code_shutdown = (c == tsr_pkg::CODE_SHUTDOWN);
	endfunction : code_shutdown

	tsr_link_if lk ();

	logic [2:0]           cs_sync_q;
	logic                 cs_lvl_q;
	logic                 shutdown_q;
	logic                 shutdown_d;
	logic                 test_q;
	logic [15:0]          temp_q;
	logic                 valid_q;
	logic [15:0]          tx_q;
	logic                 start_q;
	tsr_pkg::tsr_conv_type conv_q;
	tsr_pkg::tsr_conv_type conv_d;

	// chip select seen once second and third stage agree
	wire cs_agree  = (cs_sync_q[1] == cs_sync_q[2]);
	wire cs_rise   = cs_agree & cs_sync_q[2] & ~cs_lvl_q;
	wire cs_idle   = cs_lvl_q;
	// rx words are quiet here: serial clock is ignored while deselected
	wire [7:0] code_w   = lk.rx_byte;
	wire       code_full = (lk.rx_bits >= tsr_pkg::CODE_BITS);
	wire       cmd_take = cs_rise & code_full;
	wire       cmd_ok   = cmd_take & code_permitted(code_w);
	wire       cmd_bad  = cmd_take & ~code_permitted(code_w);
	wire       load_res = (conv_q == tsr_pkg::CV_BUSY) & CONV_DONE_I;
	wire [15:0] res_word = {CONV_RESULT_I, 1'b1, tsr_pkg::TRI_BITS};
	wire [15:0] out_word = shutdown_q ? tsr_pkg::ID_WORD : temp_q;

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			cs_sync_q <= 3'h7;
			cs_lvl_q  <= 1'b1;
		end else if (CE_I) begin
			cs_sync_q <= {cs_sync_q[1:0], CS_N_I};
			if (cs_agree) begin
				cs_lvl_q <= cs_sync_q[2];
			end
		end
	end

	// configuration: no readback path exists
	always_comb begin
		shutdown_d = shutdown_q;
		if (cmd_ok) begin
			shutdown_d = code_shutdown(code_w);
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			shutdown_q <= 1'b0;
			test_q     <= 1'b0;
		end else if (CE_I) begin
			shutdown_q <= shutdown_d;
			// unpermitted codes are ignored and flagged
			if (cmd_bad) begin
				test_q <= 1'b1;
			end
		end
	end

	// conversion sequencing
	always_comb begin
		conv_d = conv_q;
		unique case (conv_q)
			tsr_pkg::CV_IDLE: begin
				if (!shutdown_q) begin
					conv_d = tsr_pkg::CV_BUSY;
				end
			end
			tsr_pkg::CV_BUSY: begin
				if (CONV_DONE_I) begin
					conv_d = tsr_pkg::CV_IDLE;
				end else if (shutdown_q) begin
					conv_d = tsr_pkg::CV_DRAIN;
				end
			end
			tsr_pkg::CV_DRAIN: begin
				// result of a conversion begun before shutdown is dropped
				if (CONV_DONE_I) begin
					conv_d = tsr_pkg::CV_IDLE;
				end
			end
			default: begin
				conv_d = tsr_pkg::CV_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			conv_q  <= tsr_pkg::CV_IDLE;
			start_q <= 1'b0;
		end else if (CE_I) begin
			conv_q  <= conv_d;
			start_q <= (conv_q == tsr_pkg::CV_IDLE) & ~shutdown_q;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			temp_q  <= tsr_pkg::TEMP_POR;
			valid_q <= 1'b0;
		end else if (CE_I) begin
			if (load_res) begin
				temp_q  <= res_word;
				valid_q <= 1'b1;
			end
		end
	end

	// shadow word frozen once the synchronised chip select goes low, a few clocks into the frame; refreshed once deselected
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			tx_q <= tsr_pkg::TEMP_POR;
		end else if (CE_I) begin
			if (cs_idle) begin
				tx_q <= out_word;
			end
		end
	end

	// link keeps running in every mode
	tsr_link u_link (
		.serial_clock_in_i (SERIAL_CLOCK_IN_I),
		.cs_n_i            (CS_N_I),
		.sio_i             (SIO_I),
		.sio_o             (SIO_O),
		.sio_oe_o          (SIO_OE_O),
		.lk                (lk.lnk)
	);

	assign lk.tx_word   = tx_q;
	assign CONV_START_O = start_q;
	assign SHUTDOWN_O   = shutdown_q;
	assign CONV_VALID_O = valid_q;
	assign TEST_CODE_O  = test_q;
endmodule : tsr_top
`default_nettype wire

// ==== test/tsr_asserts.sv ====
// checker: properties on the top ports
`default_nettype none
module tsr_asserts (
	// watched ports
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic CS_N_I,
	input wire logic SIO_OE_O,
	input wire logic CONV_START_O,
	input wire logic CONV_DONE_I,
	input wire logic SHUTDOWN_O,
	input wire logic CONV_VALID_O,
	input wire logic TEST_CODE_O
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	idle_undriven_a: assert property (CS_N_I |-> !SIO_OE_O) else $error("driven idle");
	first_bit_a: assert property ($fell(CS_N_I) |-> SIO_OE_O) else $error("no first bit");
	start_pulse_a: assert property (CONV_START_O |=> !CONV_START_O) else $error("long start");
	boot_start_a: assert property ($rose(RST_N_I) |=> ##[0:1] CONV_START_O) else $error("no start");
	quiet_shutdown_a: assert property (SHUTDOWN_O && $past(SHUTDOWN_O) |-> !CONV_START_O)
		else $error("start in shutdown");
	mode_idle_a: assert property ($changed(SHUTDOWN_O) |-> $past(CS_N_I, 3)) else $error("mode in frame");
	valid_cause_a: assert property ($rose(CONV_VALID_O) |-> $past(CONV_DONE_I) || $past(CONV_DONE_I, 2))
		else $error("valid no done");
	valid_hold_a: assert property (CONV_VALID_O |=> CONV_VALID_O) else $error("valid lost");
	test_hold_a: assert property (TEST_CODE_O |=> TEST_CODE_O) else $error("test lost");
endmodule : tsr_asserts
`default_nettype wire

// ==== test/tsr_host_model.sv ====
// host model: serial master, clock idles low between frames
`default_nettype none
module tsr_host_model (
	// serial pins
	output logic      sc_o,
	output logic      cs_n_o,
	output logic      sd_o,
	input  wire logic sio_i,
	input  wire logic oe_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {sc_o, cs_n_o, sd_o} = 3'b010;
	// half-ns offset keeps pin edges off rising system clock edges
	task automatic frame(input logic [15:0] wr, input int nw, output logic [15:0] rd, output logic [1:0] oe_lo);
		#0.5 cs_n_o = 1'b0;
		#160;
		for (int i = 0; i < 16 + nw; i++) begin
			sd_o = i < 16 ? ~sd_o : wr[nw + 15 - i];
			#6 sc_o = 1'b1;
			if (i < 16) rd[15 - i] = sio_i;
			if (i > 13 && i < 16) oe_lo[15 - i] = oe_i;
			#6 sc_o = 1'b0;
		end
		#3 cs_n_o = 1'b1;
		#160;
	endtask : frame
endmodule : tsr_host_model
`default_nettype wire

// ==== test/tsr_tb_top.sv ====
// testbench: sensor block, host model, converter stub
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %h got %h", n, e, g); end end
module tsr_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0, rst_n = 1'b0, done = 1'b0;
	logic [12:0] res = 13'h0000, last;
	logic        sc, cs_n, sd, sio_o, sio_oe, start, shut, valid, tcode;
	int          err_total = 0, checks_done = 0, seed = 85, starts = 0, used = 0;
	wire logic   sio = sio_oe ? sio_o : sd;
	tsr_top dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .SERIAL_CLOCK_IN_I(sc), .CS_N_I(cs_n), .SIO_I(sio),
		.SIO_O(sio_o), .SIO_OE_O(sio_oe), .CONV_START_O(start), .CONV_DONE_I(done), .CONV_RESULT_I(res),
		.SHUTDOWN_O(shut), .CONV_VALID_O(valid), .TEST_CODE_O(tcode));
	tsr_host_model host (.sc_o(sc), .cs_n_o(cs_n), .sd_o(sd), .sio_i(sio), .oe_i(sio_oe));
	function automatic logic [15:0] conv_word(input logic [12:0] r);
		return {r, 1'b1, 2'h0};
	endfunction : conv_word
	task automatic complete_run();
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	// upper byte random: only the low byte counts
	task automatic xfer(input logic [7:0] code, input int nw, input logic [15:0] exp_w);
		logic [15:0] rd;
		logic [1:0]  oe_lo;
		host.frame({8'($random(seed)), code}, nw, rd, oe_lo);
		`CHK("word", exp_w[15:2], rd[15:2])
		`CHK("tail oe", 2'h0, oe_lo)
		@(posedge clk);
	endtask : xfer
	// starts may pass during a frame, so they are counted
	always @(posedge clk) if (start === 1'b1) starts <= starts + 1;
	task automatic convert(input logic [12:0] r);
		int n;
		n = 0;
		while (starts == used && n < 60) begin
			@(posedge clk);
			n++;
		end
		if (n == 60) begin
			err_total++;
			complete_run();
		end
		used++;
		repeat (3) @(posedge clk);
		done <= 1'b1;
		res <= r;
		@(posedge clk);
		done <= 1'b0;
		last = r;
	endtask : convert
	initial forever #12.5 clk = ~clk;
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		xfer(8'h00, 16, tsr_pkg::TEMP_POR);
		`CHK("valid", 1'b0, valid)
		for (int k = 0; k < 4; k++) begin
			convert(k == 0 ? 13'h1000 : 13'($random(seed)));
			repeat (4) @(posedge clk);
			xfer(8'h00, 16, conv_word(last));
		end
		fork
			xfer(8'h00, 16, conv_word(last));
			convert(13'h0fff);
		join
		repeat (4) @(posedge clk);
		xfer(8'hff, 16, conv_word(13'h0fff));
		`CHK("shutdown", 1'b1, shut)
		convert(13'h0123);
		xfer(8'h55, 16, tsr_pkg::ID_WORD);
		`CHK("test code", 1'b1, tcode)
		xfer(8'h01, 7, tsr_pkg::ID_WORD);
		`CHK("short write", 1'b1, shut)
		xfer(8'h01, 16, tsr_pkg::ID_WORD);
		`CHK("shutdown", 1'b0, shut)
		xfer(8'h00, 8, conv_word(13'h0fff));
		for (int c = 0; c < 8; c++) begin
			xfer(8'hff, 16, conv_word(13'h0fff));
			xfer(8'((1 << c) - 1), 16, tsr_pkg::ID_WORD);
			`CHK("shutdown", 1'b0, shut)
		end
		// first done only clears the conversion cut by the first shutdown of the loop
		convert(13'h0abc);
		convert(13'($random(seed)));
		repeat (4) @(posedge clk);
		xfer(8'h00, 16, conv_word(last));
		complete_run();
	end
endmodule : tsr_tb_top
bind tsr_top tsr_asserts chk (.CLK_SYS_I, .RST_N_I, .CS_N_I, .SIO_OE_O, .CONV_START_O, .CONV_DONE_I,
	.SHUTDOWN_O, .CONV_VALID_O, .TEST_CODE_O);
`default_nettype wire
